// ### verilog/ptm_timer.sv
`timescale 1ns/1ns
// What this block does
// [RQ1] Mode field selects compare, capture, PWM/pulse, timer
// [RQ2] Compare, clear select low: period match clears, both flags
// [RQ3] Clear select high: A match clears, A flag only
// [RQ4] Software never sets A value zero in compare mode
// [RQ5] Compare mode: A match sets, clears or toggles pin
// [RQ6] Run rising edge loads pin initial level
// [RQ7] Timer mode counts like compare, pin unused
// [RQ8] Software picks PWM with mode 10, function 10
// [RQ9] PWM period equals period value, zero gives 1024
// [RQ10] PWM duty is A value, full when A >= period
// [RQ11] PWM raises A flag and P flag on matches
// [RQ12] PWM level, inversion, forced inactive or active
// [RQ13] Forced PWM level keeps counting and comparing
// [RQ14] Software picks single pulse with function 11, unchanged
// [RQ15] Pin edge sets run; run rise starts pulse
// [RQ16] Pulse ends on run clear or A match
// [RQ17] Pulse counter resets only on run rise
// [RQ18] Capture edge copies counter into A, raises flag
// [RQ19] Capture: period match clears counter, raises flag
// [RQ20] Capture function 11 disables capture, counter runs
// [RQ21] Capture sees pin edges always; ignores clear/level bits
// [RQ22] A writes direct when stopped, at reload when running
// [RQ23] Ten-bit values split low byte, two-bit high
// [RQ24] Capture edge: rising, falling, both, disabled
// [RQ25] Capture source: output pins or external clock pin
// [RQ26] Counter advances per tick while running, not paused
module ptm_timer (
    input  wire logic        clk_in,            // System clock, 20 MHz
    input  wire logic        reset_in,          // Synchronous, active high
    input  wire logic        ce_in,             // Clock enable, freezes all state
    input  wire logic        wb_cyc_in,         // Wishbone cycle
    input  wire logic        wb_stb_in,         // Wishbone strobe
    input  wire logic        wb_we_in,          // Wishbone write enable
    input  wire logic [7:0]  wb_adr_in,         // Wishbone byte address
    input  wire logic [3:0]  wb_sel_in,         // Wishbone byte lanes
    input  wire logic [31:0] wb_dat_in,         // Wishbone write data
    output logic      [31:0] wb_dat_out,        // Wishbone read data
    output logic             wb_ack_out,        // Wishbone acknowledge
    input  wire logic        ext_clock_pin_in,  // External clock / trigger pin
    input  wire logic        timer_out_pin_0_in,// Capture input, pin 0
    input  wire logic        timer_out_pin_1_in,// Capture input, pin 1
    output logic             timer_out_pin_out, // Waveform output level
    output logic             timer_out_oe_out   // High while the block drives the pin
);
    // Pin synchronisers: stage one feeds only stage two
    logic [2:0] sync1_ff;
    logic [2:0] sync2_ff;
    logic [2:0] prev_ff;        // Last synchronised level, edge detection
    logic [2:0] nxt_sync1, nxt_sync2, nxt_prev;

    // Software-visible and internal register state
    logic [7:0] ctrl0_ff;       // Pause, clock select, run
    logic [7:0] ctrl1_ff;       // timer_control_1
    logic [1:0] misc_ff;        // Adjust switch and capture pin choice
    logic [9:0] period_ff;      // period_value
    logic [9:0] cmp_a_ff;       // Value the A comparator uses
    logic [9:0] cmp_buf_ff;     // Staged A value written while running
    logic       cmp_pend_ff;    // Staged value waits for a reload
    logic [1:0] flag_ff;        // cmp_a_flag and cmp_p_flag
    logic [9:0] cnt_ff;         // Ten-bit up counter
    logic       run_prev_ff;    // Run bit one cycle ago
    logic [7:0] pre_ff;         // Free prescaler for internal ticks
    logic       level_ff;       // Compare-mode pin level before inversion
    logic       pin_ff;         // Registered pin level
    logic       oe_ff;          // Registered pin enable
    logic       ack_ff;         // Bus acknowledge
    logic [31:0] dat_ff;        // Bus read data

    logic [7:0]  nxt_ctrl0, nxt_ctrl1, nxt_pre;
    logic [9:0]  nxt_period, nxt_cmp_a, nxt_cmp_buf, nxt_cnt;
    logic [1:0]  nxt_misc, nxt_flag;
    logic        nxt_cmp_pend, nxt_run_prev, nxt_level, nxt_pin, nxt_oe, nxt_ack;
    logic [31:0] nxt_dat;

    // Decoded fields
    ptm_pkg::ptm_mode_t mode;
    logic [1:0] func;
    logic [2:0] cks;
    logic       run, pause, init_lvl, invert, cclr, compare_adjust_switch;

    assign mode     = ptm_pkg::ptm_mode_t'(ctrl1_ff[ptm_pkg::CTRL1_MODE_HI:
                                                    ptm_pkg::CTRL1_MODE_LO]); // [RQ1]
    assign func     = ctrl1_ff[ptm_pkg::CTRL1_FUNC_HI:ptm_pkg::CTRL1_FUNC_LO];
    assign cks      = ctrl0_ff[ptm_pkg::CTRL0_CKS_HI:ptm_pkg::CTRL0_CKS_LO];
    assign run      = ctrl0_ff[ptm_pkg::CTRL0_RUN];
    assign pause    = ctrl0_ff[ptm_pkg::CTRL0_PAUSE];
    assign init_lvl = ctrl1_ff[ptm_pkg::CTRL1_INIT];
    assign invert   = ctrl1_ff[ptm_pkg::CTRL1_INV];
    assign cclr     = ctrl1_ff[ptm_pkg::CTRL1_CCLR];
    assign compare_adjust_switch   = misc_ff[ptm_pkg::MISC_ADJ];

    // Pin edges: bit 0 external clock, bits 1-2 output pins
    logic [2:0] rise;
    logic [2:0] fall;
    assign rise = sync2_ff & ~prev_ff;
    assign fall = ~sync2_ff & prev_ff;

    // Counter tick from the selected source
    function automatic logic sel_tick(input logic [2:0] sel, input logic [7:0] pre,
                                      input logic er, input logic ef);
        logic t;
        t = 1'b0;
        case (sel)
            ptm_pkg::CKS_DIV4:  t = (pre & ptm_pkg::DIV4_MASK) == ptm_pkg::DIV4_MASK;
            ptm_pkg::CKS_SYS:   t = 1'b1;
            ptm_pkg::CKS_DIV16: t = (pre & ptm_pkg::DIV16_MASK) == ptm_pkg::DIV16_MASK;
            ptm_pkg::CKS_DIV64: t = (pre & ptm_pkg::DIV64_MASK) == ptm_pkg::DIV64_MASK;
            ptm_pkg::CKS_TBC:   t = pre == ptm_pkg::TBC_MASK;
            ptm_pkg::CKS_HI:    t = 1'b1;
            ptm_pkg::CKS_EXTR:  t = er;
            ptm_pkg::CKS_EXTF:  t = ef;
            default:            t = 1'b0;
        endcase
        return t;
    endfunction

    // Register read mux, reserved bits read zero
    function automatic logic [31:0] rd_mux(input logic [7:0] adr, input logic [7:0] c0,
                                           input logic [7:0] c1, input logic [9:0] cnt,
                                           input logic [9:0] ca, input logic [9:0] per,
                                           input logic [1:0] fl, input logic [1:0] ms);
        logic [31:0] d;
        d = 32'h0000_0000;
        case (adr)
            ptm_pkg::ADR_CTRL0:   d[7:0] = c0;
            ptm_pkg::ADR_CTRL1:   d[7:0] = c1;
            ptm_pkg::ADR_CNT_LO:  d[7:0] = cnt[7:0];
            ptm_pkg::ADR_CNT_HI:  d[1:0] = cnt[9:8];
            ptm_pkg::ADR_CMPA_LO: d[7:0] = ca[7:0];  // [RQ23]
            ptm_pkg::ADR_CMPA_HI: d[1:0] = ca[9:8];  // [RQ23]
            ptm_pkg::ADR_PER_LO:  d[7:0] = per[7:0];
            ptm_pkg::ADR_PER_HI:  d[1:0] = per[9:8];
            ptm_pkg::ADR_FLAGS:   d[1:0] = fl;
            ptm_pkg::ADR_MISC:    d[1:0] = ms;
            default:              d = 32'h0000_0000; // Unmapped reads zero
        endcase
        return d;
    endfunction

    // Synchroniser next values
    always_comb begin
        nxt_sync1 = {timer_out_pin_1_in, timer_out_pin_0_in, ext_clock_pin_in};
        nxt_sync2 = sync1_ff;
        nxt_prev  = sync2_ff;
    end

    always_ff @(posedge clk_in) begin
        if (reset_in) begin
            sync1_ff <= 3'h0;
            sync2_ff <= 3'h0;
            prev_ff  <= 3'h0;
        end else if (ce_in) begin
            sync1_ff <= nxt_sync1;
            sync2_ff <= nxt_sync2;
            prev_ff  <= nxt_prev;
        end
    end

    // Timer and bus working values
    logic        wr, bus_req, tick, run_rise, p_hit, a_hit, reload;
    logic        cap_src, cap_r, cap_f, cap_hit, single, active, ext_trig;
    logic [10:0] inc, per_end;

    // Bus, registers, counter and pin next values
    always_comb begin
        nxt_ctrl0    = ctrl0_ff;
        nxt_ctrl1    = ctrl1_ff;
        nxt_misc     = misc_ff;
        nxt_period   = period_ff;
        nxt_cmp_a    = cmp_a_ff;
        nxt_cmp_buf  = cmp_buf_ff;
        nxt_cmp_pend = cmp_pend_ff;
        nxt_flag     = flag_ff;
        nxt_cnt      = cnt_ff;
        nxt_run_prev = run;
        nxt_pre      = pre_ff + 8'h01;
        nxt_level    = level_ff;
        nxt_pin      = 1'b0;
        nxt_oe       = 1'b0;
        cap_hit      = 1'b0;
        active       = 1'b0;

        // One-wait-state slave; ack drops the cycle after it rose
        bus_req = wb_cyc_in && wb_stb_in && !ack_ff;
        wr      = bus_req && wb_we_in && wb_sel_in[0];
        nxt_ack = bus_req;
        nxt_dat = bus_req ? rd_mux(wb_adr_in, ctrl0_ff, ctrl1_ff, cnt_ff, cmp_a_ff,
                                   period_ff, flag_ff, misc_ff) : 32'h0000_0000;

        // Software writes, low byte lane only
        if (wr) begin
            case (wb_adr_in)
                ptm_pkg::ADR_CTRL0:  nxt_ctrl0 = {wb_dat_in[7:3], 3'h0};
                ptm_pkg::ADR_CTRL1:  nxt_ctrl1 = wb_dat_in[7:0];
                ptm_pkg::ADR_PER_LO: nxt_period[7:0] = wb_dat_in[7:0];
                ptm_pkg::ADR_PER_HI: nxt_period[9:8] = wb_dat_in[1:0]; // [RQ23]
                ptm_pkg::ADR_FLAGS:  nxt_flag = flag_ff & ~wb_dat_in[1:0];
                ptm_pkg::ADR_MISC:   nxt_misc = wb_dat_in[1:0];
                ptm_pkg::ADR_CMPA_LO, ptm_pkg::ADR_CMPA_HI: begin
                    // Adjust switch set makes A read only
                    if (!compare_adjust_switch) begin // [RQ22]
                        if (wb_adr_in == ptm_pkg::ADR_CMPA_LO)
                            nxt_cmp_buf[7:0] = wb_dat_in[7:0];
                        else
                            nxt_cmp_buf[9:8] = wb_dat_in[1:0];
                        // Stopped: straight to comparator; running: staged
                        if (!run)
                            nxt_cmp_a = nxt_cmp_buf; // [RQ22]
                        else
                            nxt_cmp_pend = 1'b1; // [RQ22]
                    end
                end
                default: ; // Unmapped writes ignored
            endcase
        end

        single   = mode == ptm_pkg::MODE_PWM && func == ptm_pkg::FUNC_11;
        run_rise = run && !run_prev_ff;
        tick     = run && !pause && !run_rise &&
                   sel_tick(cks, pre_ff, rise[0], fall[0]); // [RQ26]
        inc      = {1'b0, cnt_ff} + ptm_pkg::CNT_ONE;
        // Zero period runs all 1024 counts
        per_end  = (period_ff == ptm_pkg::VAL_RST) ? ptm_pkg::CNT_FULL
                                                   : {1'b0, period_ff}; // [RQ9] [RQ19]
        p_hit    = tick && inc == per_end;
        a_hit    = tick && inc == {1'b0, cmp_a_ff};
        reload   = run_rise;

        // Trigger edge follows the external clock sense
        ext_trig = (cks == ptm_pkg::CKS_EXTF) ? fall[0] : rise[0];

        // Capture source and edge selection
        cap_src = ctrl1_ff[ptm_pkg::CTRL1_CAPTS];
        cap_r   = cap_src ? rise[0] : (misc_ff[ptm_pkg::MISC_PINSEL] ? rise[2] : rise[1]); // [RQ25]
        cap_f   = cap_src ? fall[0] : (misc_ff[ptm_pkg::MISC_PINSEL] ? fall[2] : fall[1]); // [RQ25]

        // Counting: reset on run rise in every mode
        if (run_rise) begin
            nxt_cnt = 10'h000; // [RQ17]
        end else if (tick) begin
            nxt_cnt = inc[9:0]; // [RQ26]
        end

        case (mode)
            ptm_pkg::MODE_CMP, ptm_pkg::MODE_TMR: begin
                if (cclr) begin
                    // A match clears; period flag never raised here
                    if (a_hit) begin
                        nxt_cnt     = 10'h000; // [RQ3] [RQ7]
                        nxt_flag[ptm_pkg::FLAG_A] = 1'b1; // [RQ3]
                        reload      = 1'b1;
                    end
                end else begin
                    if (a_hit)
                        nxt_flag[ptm_pkg::FLAG_A] = 1'b1; // [RQ2] [RQ7]
                    if (p_hit) begin
                        nxt_cnt     = 10'h000; // [RQ2] [RQ7]
                        nxt_flag[ptm_pkg::FLAG_P] = 1'b1; // [RQ2]
                        reload      = 1'b1;
                    end
                end
            end
            ptm_pkg::MODE_PWM: begin
                if (single) begin
                    // Pin active edge starts the pulse by setting run
                    if (ext_trig && !run)
                        nxt_ctrl0[ptm_pkg::CTRL0_RUN] = 1'b1; // [RQ15]
                    if (a_hit) begin
                        nxt_ctrl0[ptm_pkg::CTRL0_RUN] = 1'b0; // [RQ16]
                        nxt_flag[ptm_pkg::FLAG_A] = 1'b1; // [RQ16]
                    end
                end else begin
                    // Period match ends the PWM cycle, clear select ignored
                    if (a_hit)
                        nxt_flag[ptm_pkg::FLAG_A] = 1'b1; // [RQ11] [RQ13]
                    if (p_hit) begin
                        nxt_cnt     = 10'h000; // [RQ9] [RQ13]
                        nxt_flag[ptm_pkg::FLAG_P] = 1'b1; // [RQ11]
                        reload      = 1'b1;
                    end
                end
            end
            ptm_pkg::MODE_CAP: begin
                // Pin edges count even when the pin is an output elsewhere
                case (func)
                    ptm_pkg::FUNC_00: cap_hit = cap_r; // [RQ24] [RQ21]
                    ptm_pkg::FUNC_01: cap_hit = cap_f; // [RQ24]
                    ptm_pkg::FUNC_10: cap_hit = cap_r || cap_f; // [RQ24]
                    default:          cap_hit = 1'b0; // [RQ20]
                endcase
                if (p_hit) begin
                    nxt_cnt     = 10'h000; // [RQ19]
                    nxt_flag[ptm_pkg::FLAG_P] = 1'b1; // [RQ19]
                end
                if (cap_hit && run) begin
                    nxt_cmp_a   = cnt_ff; // [RQ18]
                    nxt_cmp_buf = cnt_ff;
                    nxt_cmp_pend = 1'b0;
                    nxt_flag[ptm_pkg::FLAG_A] = 1'b1; // [RQ18]
                end
            end
            default: ;
        endcase

        // Staged A value moves to the comparator at a reload
        if (reload && cmp_pend_ff && !cap_hit) begin
            nxt_cmp_a    = cmp_buf_ff; // [RQ22]
            nxt_cmp_pend = 1'b0;
        end

        // Pin waveform
        case (mode)
            ptm_pkg::MODE_CMP: begin
                if (run_rise) begin
                    nxt_level = init_lvl; // [RQ6]
                end else if (a_hit) begin
                    case (func)
                        ptm_pkg::FUNC_01: nxt_level = 1'b0; // [RQ5]
                        ptm_pkg::FUNC_10: nxt_level = 1'b1; // [RQ5]
                        ptm_pkg::FUNC_11: nxt_level = !level_ff; // [RQ5]
                        default:          nxt_level = level_ff; // [RQ5]
                    endcase
                end
                nxt_pin = nxt_level ^ invert;
                nxt_oe  = 1'b1;
            end
            ptm_pkg::MODE_PWM: begin
                // Duty comes from A; A at or above period stays active
                case (func)
                    ptm_pkg::FUNC_00: active = 1'b0; // [RQ12]
                    ptm_pkg::FUNC_01: active = 1'b1; // [RQ12]
                    ptm_pkg::FUNC_10: active = nxt_cnt < cmp_a_ff; // [RQ10]
                    default:          active = nxt_ctrl0[ptm_pkg::CTRL0_RUN]; // [RQ15] [RQ16]
                endcase
                nxt_pin = (active ? init_lvl : !init_lvl) ^ invert; // [RQ12]
                nxt_oe  = 1'b1;
            end
            default: begin
                // Timer and capture modes leave the pin free
                nxt_pin = 1'b0; // [RQ7] [RQ21]
                nxt_oe  = 1'b0;
            end
        endcase
    end

    // Enable low freezes bus and timer alike
    always_ff @(posedge clk_in) begin
        if (reset_in) begin
            ctrl0_ff    <= ptm_pkg::CTRL_RST;
            ctrl1_ff    <= ptm_pkg::CTRL_RST;
            misc_ff     <= 2'h0;
            period_ff   <= ptm_pkg::VAL_RST;
            cmp_a_ff    <= ptm_pkg::VAL_RST;
            cmp_buf_ff  <= ptm_pkg::VAL_RST;
            cmp_pend_ff <= 1'b0;
            flag_ff     <= 2'h0;
            cnt_ff      <= ptm_pkg::VAL_RST;
            run_prev_ff <= 1'b0;
            pre_ff      <= 8'h00;
            level_ff    <= 1'b0;
            pin_ff      <= 1'b0;
            oe_ff       <= 1'b0;
            ack_ff      <= 1'b0;
            dat_ff      <= 32'h0000_0000;
        end else if (ce_in) begin
            ctrl0_ff    <= nxt_ctrl0;
            ctrl1_ff    <= nxt_ctrl1;
            misc_ff     <= nxt_misc;
            period_ff   <= nxt_period;
            cmp_a_ff    <= nxt_cmp_a;
            cmp_buf_ff  <= nxt_cmp_buf;
            cmp_pend_ff <= nxt_cmp_pend;
            flag_ff     <= nxt_flag;
            cnt_ff      <= nxt_cnt;
            run_prev_ff <= nxt_run_prev;
            pre_ff      <= nxt_pre;
            level_ff    <= nxt_level;
            pin_ff      <= nxt_pin;
            oe_ff       <= nxt_oe;
            ack_ff      <= nxt_ack;
            dat_ff      <= nxt_dat;
        end
    end

    assign wb_dat_out        = dat_ff;
    assign wb_ack_out        = ack_ff;
    assign timer_out_pin_out = pin_ff;
    assign timer_out_oe_out  = oe_ff;
endmodule

// ### verilog/ptm_pkg.sv
// Shared constants of the periodic timer
package ptm_pkg;
    // Register byte offsets on the Wishbone slave
    localparam logic [7:0] ADR_CTRL0    = 8'h00; // Pause, clock select, run
    localparam logic [7:0] ADR_CTRL1    = 8'h04; // timer_control_1
    localparam logic [7:0] ADR_CNT_LO   = 8'h08; // Counter bits 7..0, read only
    localparam logic [7:0] ADR_CNT_HI   = 8'h0c; // Counter bits 9..8, read only
    localparam logic [7:0] ADR_CMPA_LO  = 8'h10; // compare_a_low
    localparam logic [7:0] ADR_CMPA_HI  = 8'h14; // compare_a_high
    localparam logic [7:0] ADR_PER_LO   = 8'h18; // period_value_low
    localparam logic [7:0] ADR_PER_HI   = 8'h1c; // period_value_high
    localparam logic [7:0] ADR_FLAGS    = 8'h20; // Comparator flags, write one to clear
    localparam logic [7:0] ADR_MISC     = 8'h24; // Adjust switch, capture pin choice

    // Bit positions in control 0
    localparam int CTRL0_PAUSE   = 7;
    localparam int CTRL0_CKS_HI  = 6;
    localparam int CTRL0_CKS_LO  = 4;
    localparam int CTRL0_RUN     = 3;
    // Bit positions in timer_control_1
    localparam int CTRL1_MODE_HI = 7;
    localparam int CTRL1_MODE_LO = 6;
    localparam int CTRL1_FUNC_HI = 5;
    localparam int CTRL1_FUNC_LO = 4;
    localparam int CTRL1_INIT    = 3;
    localparam int CTRL1_INV     = 2;
    localparam int CTRL1_CAPTS   = 1;
    localparam int CTRL1_CCLR    = 0;
    // Flag and misc bit positions
    localparam int FLAG_A        = 0;
    localparam int FLAG_P        = 1;
    localparam int MISC_ADJ      = 0;
    localparam int MISC_PINSEL   = 1;

    // Reset values
    localparam logic [7:0] CTRL_RST  = 8'h00;
    localparam logic [9:0] VAL_RST   = 10'h000;

    // Counter limits
    localparam logic [10:0] CNT_FULL = 11'h400; // 1024 counts when period is zero
    localparam logic [10:0] CNT_ONE  = 11'h001;

    // Prescaler masks: a tick when all masked bits are ones
    localparam logic [7:0] DIV4_MASK  = 8'h03;
    localparam logic [7:0] DIV16_MASK = 8'h0f;
    localparam logic [7:0] DIV64_MASK = 8'h3f;
    localparam logic [7:0] TBC_MASK   = 8'hff;

    // Operating modes
    typedef enum logic [1:0] {
        MODE_CMP = 2'h0,
        MODE_CAP = 2'h1,
        MODE_PWM = 2'h2,
        MODE_TMR = 2'h3
    } ptm_mode_t;

    // Output function field codes
    localparam logic [1:0] FUNC_00 = 2'h0;
    localparam logic [1:0] FUNC_01 = 2'h1;
    localparam logic [1:0] FUNC_10 = 2'h2;
    localparam logic [1:0] FUNC_11 = 2'h3;

    // Clock select codes
    localparam logic [2:0] CKS_DIV4  = 3'h0;
    localparam logic [2:0] CKS_SYS   = 3'h1;
    localparam logic [2:0] CKS_DIV16 = 3'h2;
    localparam logic [2:0] CKS_DIV64 = 3'h3;
    localparam logic [2:0] CKS_TBC   = 3'h4;
    localparam logic [2:0] CKS_HI    = 3'h5;
    localparam logic [2:0] CKS_EXTR  = 3'h6;
    localparam logic [2:0] CKS_EXTF  = 3'h7;
endpackage

// ### tb/ptm_timer_checker.sv
`timescale 1ns/1ns
// Port checks; shadows follow taken writes
module ptm_timer_checker (
    input wire logic        clk_in,
    input wire logic        reset_in,
    input wire logic        wb_cyc_in,
    input wire logic        wb_stb_in,
    input wire logic        wb_we_in,
    input wire logic [7:0]  wb_adr_in,
    input wire logic [3:0]  wb_sel_in,
    input wire logic [31:0] wb_dat_in,
    input wire logic [31:0] wb_dat_out,
    input wire logic        wb_ack_out,
    input wire logic        timer_out_pin_out,
    input wire logic        timer_out_oe_out
);
    logic [7:0] c1_ff, nxt_c1;  // Control 1 as software wrote it
    logic       run_ff, nxt_run; // Run bit; misses hardware clears
    logic       tk;              // Write taken this edge
    logic       frc;             // Forced PWM level
    assign tk = wb_cyc_in & wb_stb_in & ~wb_ack_out & wb_we_in & wb_sel_in[0];
    assign frc = c1_ff[4] ? c1_ff[3] ^ c1_ff[2] : ~c1_ff[3] ^ c1_ff[2];
    // Shadow next values
    always_comb begin
        nxt_c1 = c1_ff;
        nxt_run = run_ff;
        if (tk && wb_adr_in == ptm_pkg::ADR_CTRL1) nxt_c1 = wb_dat_in[7:0];
        if (tk && wb_adr_in == ptm_pkg::ADR_CTRL0) nxt_run = wb_dat_in[3];
    end
    // Shadow registers
    always_ff @(posedge clk_in) begin
        c1_ff <= reset_in ? 8'h00 : nxt_c1;
        run_ff <= reset_in ? 1'b0 : nxt_run;
    end
    default clocking cb @(posedge clk_in); endclocking
    default disable iff (reset_in);
    ack_pulse_a: assert property (wb_ack_out |=> !wb_ack_out)
        else $error("long ack");
    ack_answer_a: assert property (wb_cyc_in && wb_stb_in && !wb_ack_out |=> wb_ack_out)
        else $error("late ack");
    read_width_a: assert property (wb_ack_out && !wb_we_in |-> wb_dat_out[31:8] == 24'h0 &&
        (!(wb_adr_in inside {8'h0c, 8'h14, 8'h1c}) || wb_dat_out[7:2] == 6'h0))
        else $error("reserved bits set");
    idle_data_a: assert property (!wb_ack_out |-> wb_dat_out == 32'h0)
        else $error("stray data");
    drive_mode_a: assert property (c1_ff[7:6] inside {2'h0, 2'h2} |=> timer_out_oe_out)
        else $error("pin not driven");
    timer_pin_a: assert property (c1_ff[7:6] == 2'h3 |=> !timer_out_oe_out && !timer_out_pin_out)
        else $error("pin used in timer mode");
    capture_pin_a: assert property (c1_ff[7:6] == 2'h1 |=> !timer_out_oe_out)
        else $error("pin driven in capture mode");
    init_level_a: assert property ($rose(run_ff) && c1_ff[7:6] == 2'h0 |->
        ##[1:3] timer_out_pin_out == (c1_ff[3] ^ c1_ff[2])) else $error("no initial level");
    pwm_force_a: assert property (c1_ff[7:5] == 3'h4 && run_ff && $stable(c1_ff) && $stable(run_ff)
        |=> timer_out_pin_out == $past(frc)) else $error("forced level wrong");
    cover property ($rose(run_ff) && c1_ff[7:6] == 2'h0);
    cover property (c1_ff[7:5] == 3'h4 && run_ff);
    cover property (wb_ack_out && !wb_we_in && wb_adr_in == ptm_pkg::ADR_CMPA_LO);
endmodule

// ### tb/ptm_pins_model.sv
`timescale 1ns/1ns
// Far-side pins: six-cycle high pulse per request
module ptm_pins_model (
    input  wire logic       clk_in,
    input  wire logic [2:0] pulse_in,
    output logic            ext_pin_out,
    output logic            pin_0_out,
    output logic            pin_1_out
);
    logic [2:0] hold [3] = '{3'h0, 3'h0, 3'h0}; // Cycles left high
    always @(posedge clk_in)
        for (int i = 0; i < 3; i++)
            hold[i] <= pulse_in[i] ? 3'h6 : (hold[i] != 3'h0 ? hold[i] - 3'h1 : 3'h0);
    assign ext_pin_out = hold[0] != 3'h0;
    assign pin_0_out = hold[1] != 3'h0;
    assign pin_1_out = hold[2] != 3'h0;
endmodule

// ### tb/ptm_timer_bench.sv
`timescale 1ns/1ns
module ptm_timer_bench;
    logic clk_in = 0, reset_in = 1, cyc = 0, stb = 0, we = 0;
    logic [7:0] adr = 0;
    logic [31:0] dat = 0, q, rdat, v;
    logic [2:0] pls = 0; // Pulse requests: pin 1, pin 0, ext pin
    logic ext, p0, p1, pin, oe, ack;
    int n_errors = 0, compares = 0, k, w;
    always #25 clk_in = ~clk_in;
    ptm_timer u_dut(.clk_in, .reset_in, .ce_in(1'b1), .wb_cyc_in(cyc), .wb_stb_in(stb),
        .wb_we_in(we), .wb_adr_in(adr), .wb_sel_in(4'h1), .wb_dat_in(dat), .wb_dat_out(rdat),
        .wb_ack_out(ack), .ext_clock_pin_in(ext), .timer_out_pin_0_in(p0),
        .timer_out_pin_1_in(p1), .timer_out_pin_out(pin), .timer_out_oe_out(oe));
    ptm_pins_model u_pins(.clk_in, .pulse_in(pls), .ext_pin_out(ext), .pin_0_out(p0),
        .pin_1_out(p1));
    task end_of_test;
        if (n_errors == 0 && compares > 0) $display("verification passed");
        else $display("verification failed");
        $finish;
    endtask
    task chk(input logic [31:0] g, input logic [31:0] e);
        compares++;
        if (g !== e) begin
            n_errors++;
            $display("mismatch t=%0t got=%h exp=%h", $time, g, e);
        end
    endtask
    // Upper write bits random; ignored
    task bus(input logic w_, input logic [7:0] a, input logic [7:0] d);
        @(posedge clk_in);
        {cyc, stb, we, adr, dat} <= {2'b11, w_, a, 24'($urandom), d};
        k = 0;
        do begin @(posedge clk_in); k++; end while (ack !== 1'b1 && k < 20);
        q = rdat;
        {cyc, stb, we} <= 3'b000;
        if (k >= 20) begin n_errors++; end_of_test; end
    endtask
    task rd(input logic [7:0] a, input logic [31:0] e);
        bus(0, a, 8'h00);
        chk(q, e);
    endtask
    // Stop first so value writes land directly
    task setv(input logic [7:0] a, input logic [7:0] p);
        bus(1, ptm_pkg::ADR_CTRL0, 8'h10);
        bus(1, ptm_pkg::ADR_CMPA_LO, a);
        bus(1, ptm_pkg::ADR_PER_LO, p);
        bus(1, ptm_pkg::ADR_PER_HI, 8'h00);
    endtask
    task go(input logic [7:0] c1, input logic [7:0] c0, input int n);
        bus(1, ptm_pkg::ADR_FLAGS, 8'h03);
        bus(1, ptm_pkg::ADR_CTRL1, c1);
        bus(1, ptm_pkg::ADR_CTRL0, c0);
        repeat (n) @(posedge clk_in);
    endtask
    task pwm(input logic [7:0] c1, input logic [7:0] a, input logic [31:0] e);
        setv(a, 16);
        go(c1, 8'h18, 40);
        w = 0;
        repeat (32) begin @(posedge clk_in); w += (pin === 1'b1); end
        chk(w, e);
        rd(ptm_pkg::ADR_FLAGS, {30'h0, 1'b1, a - 8'd1 < 8'd16});
    endtask
    initial begin
        void'($urandom(99250));
        repeat (20) @(posedge clk_in);
        reset_in <= 0;
        for (int i = 0; i < 10; i++) rd(8'(4 * i), 0);
        rd(8'h30, 0);
        repeat (4) begin
            v = $urandom;
            bus(1, ptm_pkg::ADR_PER_HI, v[15:8]);
            rd(ptm_pkg::ADR_PER_HI, {30'h0, v[9:8]});
        end
        bus(1, ptm_pkg::ADR_MISC, 8'h01);
        bus(1, ptm_pkg::ADR_CMPA_LO, 8'h5a);
        rd(ptm_pkg::ADR_CMPA_LO, 0);
        bus(1, ptm_pkg::ADR_MISC, 8'h00);
        setv(6, 10);
        rd(ptm_pkg::ADR_CMPA_LO, 6);
        go(8'hc0, 8'h18, 30);
        rd(ptm_pkg::ADR_FLAGS, 3);
        setv(6, 3);
        go(8'hc1, 8'h18, 30);
        rd(ptm_pkg::ADR_FLAGS, 1);
        bus(1, ptm_pkg::ADR_CTRL0, 8'h98);
        bus(0, ptm_pkg::ADR_CNT_LO, 0);
        v = q;
        repeat (8) @(posedge clk_in);
        rd(ptm_pkg::ADR_CNT_LO, v);
        chk(32'(v < 6), 1);
        setv(20, 0);
        go(8'h39, 8'h18, 3);
        chk(32'(pin), 1);
        pwm(8'hc0, 0, 0);
        repeat (3) begin
            v = 1 + $urandom % 15;
            pwm(8'ha8, v[7:0], 2 * v);
        end
        pwm(8'ha8, 20, 32);
        pwm(8'hac, 5, 22);
        pwm(8'h88, 5, 0);
        pwm(8'h98, 5, 32);
        setv(12, 16);
        go(8'hb8, 8'h10, 2);
        pls <= 3'b001;
        @(posedge clk_in) pls <= 0;
        w = 0;
        repeat (60) begin @(posedge clk_in); w += (pin === 1'b1); end
        chk(32'(w inside {[12:13]}), 1);
        rd(ptm_pkg::ADR_CTRL0, 8'h10);
        rd(ptm_pkg::ADR_FLAGS, 1);
        for (int f = 0; f < 4; f++) begin
            setv(0, 0);
            go(8'h40 | 8'(f << 4) | (f == 1 ? 8'h02 : 8'h00), 8'h18, 8);
            pls <= f == 1 ? 3'b001 : 3'b010;
            @(posedge clk_in) pls <= 0;
            repeat (20) @(posedge clk_in);
            rd(ptm_pkg::ADR_FLAGS, 32'(f != 3));
            bus(0, ptm_pkg::ADR_CMPA_LO, 0);
            chk(32'(q != 0), 32'(f != 3));
        end
        end_of_test;
    end
endmodule
bind ptm_timer ptm_timer_checker u_chk(.clk_in, .reset_in, .wb_cyc_in, .wb_stb_in, .wb_we_in,
    .wb_adr_in, .wb_sel_in, .wb_dat_in, .wb_dat_out, .wb_ack_out, .timer_out_pin_out,
    .timer_out_oe_out);
